// ---- rtl/adc_host_params.svh ----
// Timing constants, widths and codes shared by the converter controller files.
`ifndef ADC_HOST_PARAMS_SVH
`define ADC_HOST_PARAMS_SVH

// ----------------------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS     10
`define START_MIN_NS      50
`define ACQ_MIN_NS        200
`define RESULT_HOLD_NS    300
`define BUSY_MAX_NS       500
`define START_CYC         ((`START_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACQ_CYC           ((`ACQ_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_MAX_CYC      (`BUSY_MAX_NS / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Result format and counter width
// ----------------------------------------------------------------------------
`define RESULT_W          12
`define SIGN_BIT          11
`define CNT_W             8

`endif

// ---- rtl/adc_host_pkg.sv ----
// Types shared by the converter controller modules.
package adc_host_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACQUIRE,
    ST_START,
    ST_WAIT_BUSY,
    ST_CONVERT,
    ST_DONE
  } seq_state_t;

  typedef logic [11:0] result_t;

endpackage

// ---- rtl/adc_cycle_timer.sv ----
// Down counter that reports when a loaded number of cycles has passed.
`timescale 1ns/1ns
`default_nettype none
`include "adc_host_params.svh"

module adc_cycle_timer #(
  parameter int CW = `CNT_W
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  // Control
  input  wire logic          load,
  input  wire logic [CW-1:0] load_val,
  // Status
  output logic               expired
);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          done;
  } tmr_t;

  tmr_t s_q;
  tmr_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (load)
    begin
      s_d.cnt  = load_val;
      s_d.done = (load_val == '0);
    end
    else if (s_q.cnt != '0)
    begin
      s_d.cnt  = s_q.cnt - 1'b1;
      s_d.done = (s_q.cnt == {{(CW-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign expired = s_q.done;

endmodule
`default_nettype wire

// ---- rtl/adc_host_ctrl.sv ----
// Host-side sequencer that runs conversions on a two-step subranging converter.
//
// What this block does
// - Each conversion starts with one start pulse held high at least 50 ns.
// - After input-released falls the host may put the track/hold back to tracking.
// - With a track/hold the host allows 200 ns of acquisition before each start.
// - The host puts the track/hold into hold after the rising edge of start.
// - The host releases hold when the converter is done with the input.
`timescale 1ns/1ns
`default_nettype none
`include "adc_host_params.svh"

module adc_host_ctrl
  import adc_host_pkg::*;
#(
  parameter int RW         = `RESULT_W,
  parameter int START_CYC  = `START_CYC,
  parameter int ACQ_CYC    = `ACQ_CYC,
  parameter int TIMEOUT    = `BUSY_MAX_CYC + 4
) (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  // User command side
  input  wire logic                   conv_req,
  input  wire logic                   bipolar,
  output logic                        conv_ready,
  output logic                        sample_valid,
  output logic [RW-1:0]               sample_data,
  output logic                        sample_signed_ok,
  output logic                        conv_timeout,
  // Converter pins
  output logic                        adc_start,
  output logic                        adc_data_en_n,
  input  wire logic                   adc_busy,
  input  wire logic                   adc_input_released,
  input  wire logic [RW-1:0]          adc_result,
  // Track/hold control
  output logic                        th_hold
);

  import adc_host_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    seq_state_t     st;
    logic           start;
    logic           den_n;
    logic           hold;
    logic           ready;
    logic           valid;
    logic [RW-1:0]  data;
    logic           bip;
    logic           tmo;
    logic           busy_prev;
    logic           rel_prev;
    logic [`CNT_W-1:0] wd;
  } ctrl_t;

  ctrl_t s_q;
  ctrl_t s_d;

  // --------------------------------------------------------------------------
  // Timer hookup
  // --------------------------------------------------------------------------
  logic              tmr_load;
  logic [`CNT_W-1:0] tmr_val;
  logic              tmr_expired;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Offset binary to a two's complement view: flipping the top bit puts the
  // zero-input step between 0111..1 and 1000..0 at the sign change.
  function automatic logic [RW-1:0] to_user(input logic [RW-1:0] raw, input logic bip);
    to_user = bip ? {~raw[RW-1], raw[RW-2:0]} : raw;
  endfunction

  // A pin fell when last cycle's copy was high and the pin is now low.
  function automatic logic fell_now(input logic prev, input logic cur);
    fell_now = prev && !cur;
  endfunction

  // --------------------------------------------------------------------------
  // Phase timer
  // --------------------------------------------------------------------------
  adc_cycle_timer #(
    .CW       (`CNT_W)
  ) u_timer (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .expired  (tmr_expired)
  );

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always_comb
  begin
    s_d       = s_q;
    tmr_load  = 1'b0;
    tmr_val   = '0;
    s_d.valid = 1'b0;
    s_d.busy_prev = adc_busy;
    s_d.rel_prev  = adc_input_released;
    unique case (s_q.st)
      ST_IDLE:
      begin
        s_d.ready = 1'b1;
        if (conv_req)
        begin
          // Acquisition runs while the track/hold tracks.
          s_d.ready = 1'b0;
          s_d.bip   = bipolar;
          s_d.tmo   = 1'b0;
          s_d.st    = ST_ACQUIRE;
          tmr_load  = 1'b1;
          tmr_val   = `CNT_W'(ACQ_CYC);
        end
      end
      ST_ACQUIRE:
      begin
        if (tmr_expired)
        begin
          s_d.start = 1'b1;
          s_d.st    = ST_START;
          tmr_load  = 1'b1;
          tmr_val   = `CNT_W'(START_CYC);
        end
      end
      ST_START:
      begin
        // Hold is commanded one cycle after start rises.
        s_d.hold = 1'b1;
        if (tmr_expired)
        begin
          s_d.start = 1'b0;
          s_d.st    = ST_WAIT_BUSY;
          s_d.wd    = '0;
        end
      end
      ST_WAIT_BUSY, ST_CONVERT:
      begin
        // Busy may rise a cycle or two after start falls; the watchdog covers both states.
        s_d.wd = s_q.wd + 1'b1;
        if (adc_busy)
          s_d.st = ST_CONVERT;
        // Falling edge of input-released frees the track/hold early.
        if (fell_now(s_q.rel_prev, adc_input_released))
          s_d.hold = 1'b0;
        if (s_q.st == ST_CONVERT && fell_now(s_q.busy_prev, adc_busy))
        begin
          // Data is already valid when busy falls, so it is taken on that edge.
          s_d.data  = to_user(adc_result, s_q.bip);
          s_d.valid = 1'b1;
          s_d.hold  = 1'b0;
          s_d.st    = ST_DONE;
        end
        else if (s_q.wd >= `CNT_W'(TIMEOUT))
        begin
          // A stuck converter must not lock the host up.
          s_d.tmo   = 1'b1;
          s_d.hold  = 1'b0;
          s_d.st    = ST_DONE;
        end
      end
      ST_DONE:
      begin
        s_d.ready = 1'b1;
        s_d.st    = ST_IDLE;
      end
      default:
      begin
        // Unused codes fall back to idle rather than leave the converter hanging.
        s_d.st = ST_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q       <= '0;
      s_q.st    <= ST_IDLE;
      s_q.den_n <= 1'b0;
    end
    else
      s_q <= s_d;
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Output buffers stay enabled so the previous word is readable during the
  // next conversion.
  assign adc_data_en_n    = s_q.den_n;
  assign adc_start        = s_q.start;
  assign th_hold          = s_q.hold;
  assign conv_ready       = s_q.ready;
  assign sample_valid     = s_q.valid;
  assign sample_data      = s_q.data;
  assign sample_signed_ok = s_q.bip;
  assign conv_timeout     = s_q.tmo;

endmodule
`default_nettype wire

// ---- tb/adc_host_ctrl_assertions.sv ----
// Port-level checker for the converter controller.
`timescale 1ns/1ns
`default_nettype none
module adc_host_ctrl_assertions (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        sys_rst,
  // User side
  input wire logic        conv_req,
  input wire logic        bipolar,
  input wire logic        conv_ready,
  input wire logic        sample_valid,
  input wire logic [11:0] sample_data,
  input wire logic        sample_signed_ok,
  input wire logic        conv_timeout,
  // Converter and track/hold
  input wire logic        adc_start,
  input wire logic        adc_data_en_n,
  input wire logic        adc_busy,
  input wire logic        adc_input_released,
  input wire logic [11:0] adc_result,
  input wire logic        th_hold
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence start_pulse_s;
    adc_start[*6] ##1 !adc_start;
  endsequence
  sequence req_taken_s;
    conv_ready && conv_req;
  endsequence
  start_width_a: assert property ($rose(adc_start) |-> start_pulse_s)
    else $error("start pulse width wrong");
  acq_gap_a: assert property (req_taken_s |=> !conv_ready ##21 $rose(adc_start))
    else $error("acquisition gap wrong");
  hold_after_start_a: assert property ($rose(adc_start) |=> th_hold)
    else $error("hold not set after start");
  hold_release_a: assert property ($fell(adc_input_released) |=> !th_hold)
    else $error("hold not released");
  data_enable_a: assert property (!adc_data_en_n)
    else $error("data enable not active");
  valid_after_busy_a: assert property ($fell(adc_busy) |-> ##[1:2] sample_valid)
    else $error("no sample after busy fell");
  sample_value_a: assert property (sample_valid |->
    sample_data == (adc_result ^ {sample_signed_ok, 11'h000}))
    else $error("sample differs from result");
  no_start_busy_a: assert property (adc_busy |-> !adc_start)
    else $error("start during conversion");
  ready_again_a: assert property (sample_valid |-> ##[1:2] conv_ready)
    else $error("not ready after sample");
  timeout_release_a: assert property ($rose(conv_timeout) |-> !th_hold)
    else $error("hold kept after timeout");
endmodule
`default_nettype wire

// ---- tb/adc_dev_model.sv ----
// Behavioural model of the converter facing the controller.
`timescale 1ns/1ns
`default_nettype none
module adc_dev_model (
  // Clock and pins
  input  wire logic        core_clk,
  input  wire logic        adc_start,
  input  wire logic        adc_data_en_n,
  output logic             adc_busy = 1'b0,
  output logic             adc_input_released = 1'b0,
  output logic [11:0]      adc_result,
  // Bench controls
  input  wire logic [11:0] code,
  input  wire logic [5:0]  end_cyc,
  input  wire logic        mute
);
  logic        start_q = 1'b0;
  logic [5:0]  cnt = 6'h00;
  logic [11:0] res = 12'h000;
  always @(posedge core_clk)
  begin
    start_q <= adc_start;
    if (start_q && !adc_start && !mute)
    begin
      adc_busy <= 1'b1;
      adc_input_released <= 1'b1;
      cnt <= 6'h00;
    end
    else if (adc_busy)
    begin
      cnt <= cnt + 6'h01;
      if (cnt == 6'h25) adc_input_released <= 1'b0;
      // The old word goes bad once its hold time after start has passed.
      if (cnt == 6'h1D) res <= ~res;
      if (cnt == 6'(end_cyc - 6'h03)) res <= code;
      if (cnt == end_cyc) adc_busy <= 1'b0;
    end
  end
  // Undriven buffers show the inverse so a stale value never passes.
  assign adc_result = adc_data_en_n ? ~res : res;
endmodule
`default_nettype wire

// ---- tb/test_subranging_adc_handshake.sv ----
// Self-checking bench for the converter controller.
`timescale 1ns/1ns
`default_nettype none
module test_subranging_adc_handshake;
  import adc_host_pkg::*;
  logic core_clk = 0, sys_rst = 1, conv_req = 0, bipolar = 0;
  logic conv_ready, sample_valid, sample_signed_ok, conv_timeout;
  logic adc_start, adc_data_en_n, adc_busy, adc_input_released, th_hold;
  result_t sample_data, adc_result, code = 12'h000;
  logic [5:0] end_cyc = 6'h28;
  logic mute = 1'b0;
  result_t last_exp = 12'h000;
  logic [31:0] seed = 32'd34;
  int n_fail = 0, total_checks = 0, cyc = 0;
  always #5 core_clk = ~core_clk;
  adc_host_ctrl dut (.core_clk(core_clk), .sys_rst(sys_rst), .conv_req(conv_req),
    .bipolar(bipolar), .conv_ready(conv_ready), .sample_valid(sample_valid),
    .sample_data(sample_data), .sample_signed_ok(sample_signed_ok),
    .conv_timeout(conv_timeout), .adc_start(adc_start), .adc_data_en_n(adc_data_en_n),
    .adc_busy(adc_busy), .adc_input_released(adc_input_released),
    .adc_result(adc_result), .th_hold(th_hold));
  adc_dev_model dev (.core_clk(core_clk), .adc_start(adc_start),
    .adc_data_en_n(adc_data_en_n), .adc_busy(adc_busy),
    .adc_input_released(adc_input_released), .adc_result(adc_result),
    .code(code), .end_cyc(end_cyc), .mute(mute));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic result_t exp_data(input result_t c, input logic b);
    return b ? (c ^ 12'h800) : c;
  endfunction
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      n_fail++;
    end
  endtask
  task automatic print_verdict;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic run(input result_t c, input logic b, input logic [5:0] e, input logic d);
    int i;
    i = 0;
    while (conv_ready !== 1'b1 && i < 100)
    begin
      @(negedge core_clk);
      i++;
    end
    @(posedge core_clk);
    conv_req <= 1'b1;
    bipolar <= b;
    code <= c;
    end_cyc <= e;
    mute <= d;
    @(posedge core_clk);
    conv_req <= 1'b0;
    i = 0;
    // Step past the take edge first so a stale timeout flag is not seen.
    do
    begin
      @(negedge core_clk);
      i++;
    end
    while (sample_valid !== 1'b1 && conv_timeout !== 1'b1 && i < 120);
    check({11'h000, sample_valid}, {11'h000, ~d});
    check(sample_data, d ? last_exp : exp_data(c, b));
    check({11'h000, sample_signed_ok}, {11'h000, b});
    check({11'h000, conv_timeout}, {11'h000, d});
    check({11'h000, th_hold}, 12'h000);
    check({11'h000, adc_data_en_n}, 12'h000);
    if (!d)
      last_exp = exp_data(c, b);
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    run(12'h000, 1'b0, 6'h28, 1'b0);
    run(12'hFFF, 1'b0, 6'h30, 1'b0);
    run(12'h7FF, 1'b1, 6'h30, 1'b0);
    run(12'h800, 1'b1, 6'h28, 1'b0);
    run(12'h555, 1'b1, 6'h28, 1'b1);
    run(12'hAAA, 1'b0, 6'h2C, 1'b0);
    repeat (12)
    begin
      seed = xs(seed);
      run(seed[11:0], seed[12], 6'(6'h28 + 6'(seed[19:13] % 9)), 1'b0);
    end
    print_verdict;
  end
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      print_verdict;
    end
  end
endmodule
bind adc_host_ctrl adc_host_ctrl_assertions chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .conv_req(conv_req), .bipolar(bipolar), .conv_ready(conv_ready),
  .sample_valid(sample_valid), .sample_data(sample_data),
  .sample_signed_ok(sample_signed_ok), .conv_timeout(conv_timeout),
  .adc_start(adc_start), .adc_data_en_n(adc_data_en_n), .adc_busy(adc_busy),
  .adc_input_released(adc_input_released), .adc_result(adc_result), .th_hold(th_hold));
`default_nettype wire
